// *** retry_diag_defs.vh ***
// constants for the per-channel auto-restart and load diagnostic block
// assumes a 100 MHz reference clock; included by the design file only
`ifndef RETRY_DIAG_DEFS_VH
`define RETRY_DIAG_DEFS_VH

// ----------------------------------------
// register map (word index = address)
// ----------------------------------------
`define ADDR_RETRY_CFG0 4'h0
`define ADDR_RETRY_CFG1 4'h1
`define ADDR_CHAN_CFG0 4'h2
`define ADDR_CHAN_CFG1 4'h3
`define ADDR_FAULT0 4'h4
`define ADDR_FAULT1 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_RETRY_CNT0 4'h7
`define ADDR_RETRY_CNT1 4'h8

// ----------------------------------------
// restart configuration fields
// ----------------------------------------
`define RC_SEL 0
`define RC_UNLIM 1
`define RC_PER_LO 2
`define RC_PER_HI 3

// ----------------------------------------
// channel configuration fields
// ----------------------------------------
`define CC_PROFILE 0
`define CC_OS_DIS 1
`define CC_OLOFF_DIS 2
`define CC_OPEN_LOAD_ON_DETECT_DISABLE 3
`define CC_LOW_RANGE 4
`define CC_DIR_DIS 5
`define CC_INT_PWM 6
`define CC_FAST_SLEW 7

// ----------------------------------------
// fault register fields
// ----------------------------------------
`define FR_OS 0
`define FR_OLOFF 1
`define FR_OPEN_LOAD_ON_FLAG 2
`define FR_FAULT 3
`define FR_LATCHED 4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define ST_FULL0 4
`define ST_FULL1 5

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define OLLED_MS 150
`define RETRY_MAX 4'hf
`endif

// *** retry_diag.v ***
// two-channel auto-restart, restart counter and load diagnostic logic
// assumes comparator inputs are asynchronous and pass through synchronisers here
// How it works
// - restart enabled when select equals profile bit
// - restart starts on fault control with condition
// - restart after period chosen by bits 3:2
// - cause gone: normal run, fault flag stays
// - unlimited mode never latches the channel off while restart is enabled
// - limited mode counts restarts up to 15
// - 16th restart sets full, none left
// - fault at final restart latches channel off
// - delatch turns channel on, counter kept
// - counter cleared on reset events and disable
// - unlimited reset delatches, restart after period
// - lighting clears duration counter each restart
// - motor clears counter after first clean period
// - off-state short to supply flagged, live
// - short flag sticky until read, disable bit
// - off-state open load flagged, sticky until read
// - high range on-state open load continuous
// - high range read clears by state rule
// - low range check periodic, fast slew only
// - internal pwm checks every 150 ms off-edge
// - direct input checks each off edge
// - low range clears after clean detection read
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "retry_diag_defs.vh"

module retry_diag #(
	parameter integer OLLED_CYCLES = `OLLED_MS * 1000 * `CLK_MHZ,
	parameter integer PERIOD_UNIT = 1000000
) (
	input wire i_ref_clk,
	input wire i_reset_n,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire [1:0] i_on_request,
	input wire [1:0] i_retry_cond,
	input wire [1:0] i_fault_control_signal,
	input wire [1:0] i_delatch,
	input wire i_failsafe_enter,
	input wire i_sleep_exit,
	input wire [1:0] i_out_above_os,
	input wire [1:0] i_out_above_ol,
	input wire [1:0] i_load_below_ol,
	input wire [1:0] i_overcurrent,
	output reg [1:0] o_channel_on,
	output reg [1:0] o_oc_duration_clear,
	output reg o_fault_status_pin_n
);

	// restart period in cycles from the two-bit field
	function [31:0] period_cycles;
		input [1:0] sel;
		begin
			period_cycles = (sel + 32'h1) * PERIOD_UNIT;
		end
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [13:0] sync1_q;
	reg [13:0] sync2_q;
	wire [13:0] raw_in = {i_retry_cond, i_fault_control_signal, i_out_above_os, i_out_above_ol,
		i_load_below_ol, i_overcurrent, i_failsafe_enter, i_sleep_exit};

	// two flops on the comparator, fault and mode inputs; i_on_request and i_delatch are read without them
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= 14'h0;
			sync2_q <= 14'h0;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	wire [1:0] retry_s = sync2_q[13:12];
	wire [1:0] fc_s = sync2_q[11:10];
	wire [1:0] os_s = sync2_q[9:8];
	wire [1:0] ol_s = sync2_q[7:6];
	wire [1:0] lowi_s = sync2_q[5:4];
	wire [1:0] oc_s = sync2_q[3:2];
	wire failsafe_s = sync2_q[1];
	wire sleep_exit_s = sync2_q[0];

	// ----------------------------------------
	// configuration and state registers
	// ----------------------------------------
	reg [3:0] rcfg_q [0:1];
	reg [7:0] ccfg_q [0:1];
	reg [3:0] cnt_q [0:1];
	reg [1:0] full_q;
	reg [1:0] latched_q;
	reg [1:0] fault_q;
	reg [1:0] os_flag_q;
	reg [1:0] oloff_flag_q;
	reg [1:0] open_load_on_flag_flag_q;
	reg [1:0] open_load_on_flag_clean_q;
	reg [1:0] waiting_q;
	reg [31:0] timer_q [0:1];
	reg [31:0] olled_q [0:1];
	reg [1:0] on_prev_q;
	reg [1:0] oc_seen_q;

	wire rd_f0 = i_rd && (i_addr == `ADDR_FAULT0);
	wire rd_f1 = i_rd && (i_addr == `ADDR_FAULT1);
	wire [1:0] fault_rd = {rd_f1, rd_f0};

	// ----------------------------------------
	// per-channel logic
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : ch
			wire [7:0] cc = ccfg_q[c];
			wire [3:0] rc = rcfg_q[c];
			wire wr_rc = i_wr && (i_addr == `ADDR_RETRY_CFG0 + c);
			wire en = (rc[`RC_SEL] == cc[`CC_PROFILE]);
			// disabling edge: 1-0 for motor, 0-1 for lighting
			wire dis_edge = wr_rc && en && (i_wdata[`RC_SEL] != cc[`CC_PROFILE]);
			wire unlim_set = wr_rc && i_wdata[`RC_UNLIM];
			wire cnt_clr = failsafe_s || sleep_exit_s || dis_edge || unlim_set;
			wire on_now = i_on_request[c] && !latched_q[c] && !waiting_q[c];
			wire off_edge = on_prev_q[c] && !on_now;
			wire low = cc[`CC_LOW_RANGE];
			wire open_load_on_flag_en = !cc[`CC_OPEN_LOAD_ON_DETECT_DISABLE];
			// low range: only periodic with fast slew
			wire ll_int = cc[`CC_INT_PWM] && (olled_q[c] >= OLLED_CYCLES) && off_edge;
			wire ll_dir = !cc[`CC_INT_PWM] && off_edge;
			wire ll_chk = low && cc[`CC_FAST_SLEW] && (ll_int || ll_dir);
			wire open_load_on_flag_det = open_load_on_flag_en && (low ? (ll_chk && lowi_s[c]) : (on_now && lowi_s[c]));
			wire os_det = !on_now && !cc[`CC_OS_DIS] && os_s[c];
			wire oloff_det = !on_now && !cc[`CC_OLOFF_DIS] && ol_s[c];
			// high range clear rule; low range needs a clean check first
			wire open_load_on_flag_rdclr = fault_rd[c] && (low ? open_load_on_flag_clean_q[c]
				: (!on_now || !lowi_s[c]));

			always @(posedge i_ref_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					cnt_q[c] <= 4'h0;
					full_q[c] <= 1'b0;
					latched_q[c] <= 1'b0;
					fault_q[c] <= 1'b0;
					waiting_q[c] <= 1'b0;
					timer_q[c] <= 32'h0;
					os_flag_q[c] <= 1'b0;
					oloff_flag_q[c] <= 1'b0;
					open_load_on_flag_flag_q[c] <= 1'b0;
					open_load_on_flag_clean_q[c] <= 1'b0;
					olled_q[c] <= 32'h0;
					on_prev_q[c] <= 1'b0;
					oc_seen_q[c] <= 1'b0;
					o_oc_duration_clear[c] <= 1'b0;
				end else begin
					on_prev_q[c] <= on_now;
					o_oc_duration_clear[c] <= 1'b0;
					// fault flag: set wins over read clear
					if (fc_s[c] && retry_s[c])
						fault_q[c] <= 1'b1;
					else if (fault_rd[c])
						fault_q[c] <= 1'b0;
					// restart sequencing
					if (i_delatch[c]) begin
						latched_q[c] <= 1'b0;
						waiting_q[c] <= 1'b0;
					end else if (unlim_set && latched_q[c] && en) begin
						latched_q[c] <= 1'b0;
						waiting_q[c] <= 1'b1;
						timer_q[c] <= period_cycles(rc[`RC_PER_HI:`RC_PER_LO]);
					end else if (waiting_q[c]) begin
						if (timer_q[c] <= 32'h1) begin
							waiting_q[c] <= 1'b0;
							o_oc_duration_clear[c] <= !cc[`CC_PROFILE];
						end else
							timer_q[c] <= timer_q[c] - 32'h1;
					end else if (en && fc_s[c] && retry_s[c] && !latched_q[c]) begin
						if (!rc[`RC_UNLIM] && full_q[c] && cnt_q[c] == 4'h0) begin
							latched_q[c] <= 1'b1;
						end else begin
							waiting_q[c] <= 1'b1;
							timer_q[c] <= period_cycles(rc[`RC_PER_HI:`RC_PER_LO]);
							if (!rc[`RC_UNLIM]) begin
								if (cnt_q[c] == `RETRY_MAX && !full_q[c]) begin
									full_q[c] <= 1'b1;
									cnt_q[c] <= 4'h0;
								end else if (!full_q[c])
									cnt_q[c] <= cnt_q[c] + 4'h1;
							end
						end
					end else if (!en && fc_s[c] && retry_s[c])
						latched_q[c] <= 1'b1;
					if (cnt_clr) begin
						cnt_q[c] <= 4'h0;
						full_q[c] <= 1'b0;
					end
					// motor: first clean period clears duration count
					if (on_now && oc_s[c])
						oc_seen_q[c] <= 1'b1;
					else if (off_edge)
						oc_seen_q[c] <= 1'b0;
					if (cc[`CC_PROFILE] && off_edge && !oc_seen_q[c] && !oc_s[c])
						o_oc_duration_clear[c] <= 1'b1;
					// diagnostic flags, set wins over read
					if (os_det)
						os_flag_q[c] <= 1'b1;
					else if (fault_rd[c])
						os_flag_q[c] <= 1'b0;
					if (oloff_det)
						oloff_flag_q[c] <= 1'b1;
					else if (fault_rd[c])
						oloff_flag_q[c] <= 1'b0;
					if (open_load_on_flag_det)
						open_load_on_flag_flag_q[c] <= 1'b1;
					else if (open_load_on_flag_rdclr)
						open_load_on_flag_flag_q[c] <= 1'b0;
					if (ll_chk)
						open_load_on_flag_clean_q[c] <= !lowi_s[c];
					if (ll_chk && ll_int)
						olled_q[c] <= 32'h0;
					else if (olled_q[c] < OLLED_CYCLES)
						olled_q[c] <= olled_q[c] + 32'h1;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// configuration writes
	// ----------------------------------------
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rcfg_q[0] <= 4'h0;
			rcfg_q[1] <= 4'h0;
			ccfg_q[0] <= 8'h0;
			ccfg_q[1] <= 8'h0;
		end else if (i_wr) begin
			case (i_addr)
				`ADDR_RETRY_CFG0: rcfg_q[0] <= i_wdata[3:0];
				`ADDR_RETRY_CFG1: rcfg_q[1] <= i_wdata[3:0];
				`ADDR_CHAN_CFG0: ccfg_q[0] <= i_wdata;
				`ADDR_CHAN_CFG1: ccfg_q[1] <= i_wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// read port and outputs
	// ----------------------------------------
	wire [1:0] open_load_on_flag_live;
	assign open_load_on_flag_live[0] = o_channel_on[0] && lowi_s[0] && !ccfg_q[0][`CC_OPEN_LOAD_ON_DETECT_DISABLE];
	assign open_load_on_flag_live[1] = o_channel_on[1] && lowi_s[1] && !ccfg_q[1][`CC_OPEN_LOAD_ON_DETECT_DISABLE];
	wire [1:0] os_live;
	assign os_live[0] = !o_channel_on[0] && os_s[0] && !ccfg_q[0][`CC_OS_DIS];
	assign os_live[1] = !o_channel_on[1] && os_s[1] && !ccfg_q[1][`CC_OS_DIS];
	wire [1:0] oloff_live;
	assign oloff_live[0] = !o_channel_on[0] && ol_s[0] && !ccfg_q[0][`CC_OLOFF_DIS];
	assign oloff_live[1] = !o_channel_on[1] && ol_s[1] && !ccfg_q[1][`CC_OLOFF_DIS];

	// read data one cycle after the strobe, zero otherwise
	always @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h0;
			o_channel_on <= 2'h0;
			o_fault_status_pin_n <= 1'b1;
		end else begin
			o_channel_on[0] <= i_on_request[0] && !latched_q[0] && !waiting_q[0];
			o_channel_on[1] <= i_on_request[1] && !latched_q[1] && !waiting_q[1];
			// live fault reporting, low while latched off
			o_fault_status_pin_n <= !(|latched_q || |os_live || |oloff_live
				|| |open_load_on_flag_live);
			o_rdata <= 8'h0;
			if (i_rd) begin
				case (i_addr)
					`ADDR_RETRY_CFG0: o_rdata <= {4'h0, rcfg_q[0]};
					`ADDR_RETRY_CFG1: o_rdata <= {4'h0, rcfg_q[1]};
					`ADDR_CHAN_CFG0: o_rdata <= ccfg_q[0];
					`ADDR_CHAN_CFG1: o_rdata <= ccfg_q[1];
					`ADDR_FAULT0: o_rdata <= {3'h0, latched_q[0], fault_q[0],
						open_load_on_flag_flag_q[0], oloff_flag_q[0], os_flag_q[0]};
					`ADDR_FAULT1: o_rdata <= {3'h0, latched_q[1], fault_q[1],
						open_load_on_flag_flag_q[1], oloff_flag_q[1], os_flag_q[1]};
					`ADDR_STATUS: o_rdata <= {2'h0, full_q, 4'h0};
					`ADDR_RETRY_CNT0: o_rdata <= {cnt_q[0], 4'h0};
					`ADDR_RETRY_CNT1: o_rdata <= {cnt_q[1], 4'h0};
					default: o_rdata <= 8'h0;
				endcase
			end
		end
	end

endmodule // retry_diag

// *** load_model.sv ***
// load side model: turns short and open knobs into comparator levels
// assumes the channel state comes from the block under test
`timescale 1ns/1ps
module load_model (
	input logic [1:0] i_chan_on,
	input logic [1:0] i_short,
	input logic [1:0] i_open,
	output logic [1:0] o_above_os,
	output logic [1:0] o_above_ol,
	output logic [1:0] o_below_ol
);
	// shorted output sits above the threshold; open load shows by state
	assign o_above_os = i_short;
	assign o_above_ol = i_open & ~i_chan_on;
	assign o_below_ol = i_open & i_chan_on;
endmodule // load_model

// *** retry_diag_sva.sv ***
// checker for the restart and diagnostic block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module retry_diag_sva (
	input logic i_ref_clk,
	input logic i_reset_n,
	input logic [3:0] i_addr,
	input logic i_rd,
	input logic [7:0] o_rdata,
	input logic [1:0] i_on_request,
	input logic [1:0] o_channel_on,
	input logic [1:0] o_oc_duration_clear,
	input logic o_fault_status_pin_n
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero when idle");
	a_unmapped_zero: assert property (i_rd && i_addr > 4'h8 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_status_bits: assert property (i_rd && i_addr == 4'h6 |=> o_rdata[3:0] == 4'h0)
		else $error("status low bits set");
	a_cnt_field: assert property (i_rd && i_addr == 4'h7 |=> o_rdata[3:0] == 4'h0)
		else $error("counter low bits set");
	a_clear_pulse: assert property (o_oc_duration_clear[0] |=> !o_oc_duration_clear[0])
		else $error("duration clear longer than one cycle");
	a_on_needs_req: assert property ($rose(o_channel_on[1]) |-> $past(i_on_request[1]))
		else $error("channel on without request");
	a_latched_off: assert property (i_rd && i_addr == 4'h4 ##1 o_rdata[4]
		|-> !o_channel_on[0] && !o_fault_status_pin_n)
		else $error("latched channel not off");
	a_latch_stays: assert property (i_rd && i_addr == 4'h5 ##1 o_rdata[4]
		|-> !o_channel_on[1] [*3])
		else $error("latched channel came back");
endmodule // retry_diag_sva
bind retry_diag retry_diag_sva u_sva (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_on_request(i_on_request),
	.o_channel_on(o_channel_on), .o_oc_duration_clear(o_oc_duration_clear),
	.o_fault_status_pin_n(o_fault_status_pin_n));

// *** tb_switch_auto_retry_and_load_diagnostics.sv ***
// testbench for the restart and diagnostic block
// assumes a 100 MHz clock and short restart periods set by parameters
`timescale 1ns/1ps
module tb_switch_auto_retry_and_load_diagnostics;
	logic i_ref_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, o_rdata, d;
	logic [1:0] req = 2'h0, cond = 2'h0, fc = 2'h0, dl = 2'h0, sh = 2'h0, op = 2'h0;
	logic [1:0] on, ocl, os, ol, bl;
	logic pin_n;
	logic fs = 0, se = 0, on0_q = 0;
	int failures = 0, n_checks = 0, rises = 0, clears = 0, clears1 = 0;
	retry_diag #(.OLLED_CYCLES(50), .PERIOD_UNIT(10)) u_dut (.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_on_request(req), .i_retry_cond(cond),
		.i_fault_control_signal(fc), .i_delatch(dl), .i_failsafe_enter(fs),
		.i_sleep_exit(se), .i_out_above_os(os), .i_out_above_ol(ol), .i_load_below_ol(bl),
		.i_overcurrent(2'h0), .o_channel_on(on), .o_oc_duration_clear(ocl),
		.o_fault_status_pin_n(pin_n));
	load_model u_load (.i_chan_on(on), .i_short(sh), .i_open(op), .o_above_os(os),
		.o_above_ol(ol), .o_below_ol(bl));
	// clock and event counters: restarts and duration clears
	initial forever #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		on0_q <= on[0];
		rises <= rises + (on[0] && !on0_q);
		clears <= clears + ocl[0];
		clears1 <= clears1 + ocl[1];
	end
	task chk(input logic [7:0] v, input logic [7:0] e);
		n_checks++;
		if (v !== e) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, v, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_ref_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= v; end
		@(posedge i_ref_clk) i_wr <= 0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge i_ref_clk) begin i_rd <= 1; i_addr <= a; end
		@(posedge i_ref_clk) i_rd <= 0;
		#1 d = o_rdata;
	endtask
	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// off-state short: live on the pin, sticky until read
	task t_short;
		@(posedge i_ref_clk) sh <= 2'h1;
		repeat (6) @(posedge i_ref_clk);
		chk(pin_n, 0);
		chk(on, 2'h0);
		@(posedge i_ref_clk) sh <= 2'h0;
		repeat (6) @(posedge i_ref_clk);
		rd(4'h4); chk(d[0], 1);
		rd(4'h4); chk(d[0], 0);
		rd(4'h9); chk(d, 8'h00);
	endtask
	// off-state open load: pin recovers at once, flag waits for read
	task t_open_off;
		@(posedge i_ref_clk) op <= 2'h1;
		repeat (6) @(posedge i_ref_clk);
		chk(pin_n, 0);
		@(posedge i_ref_clk) op <= 2'h0;
		repeat (6) @(posedge i_ref_clk);
		chk(pin_n, 1);
		rd(4'h4); chk(d[1], 1);
		rd(4'h4); chk(d[1], 0);
	endtask
	// on-state open load in high range keeps channel on
	task t_open_on;
		@(posedge i_ref_clk) req <= 2'h2;
		repeat (6) @(posedge i_ref_clk);
		@(posedge i_ref_clk) op <= 2'h2;
		repeat (6) @(posedge i_ref_clk);
		chk(pin_n, 0);
		chk(on[1], 1);
		@(posedge i_ref_clk) op <= 2'h0;
		repeat (6) @(posedge i_ref_clk);
		chk(pin_n, 1);
		rd(4'h5); chk(d[2], 1);
		rd(4'h5); chk(d[2], 0);
	endtask
	// limited restarts on lighting profile until latch-off
	task t_retry;
		int i;
		int r0;
		int c0;
		wr(4'h0, 8'h00);
		@(posedge i_ref_clk) req[0] <= 1;
		repeat (6) @(posedge i_ref_clk);
		@(posedge i_ref_clk) begin cond[0] <= 1; fc[0] <= 1; r0 = rises; c0 = clears; end
		for (i = 0; i < 400 && d[4] !== 1'b1; i++) begin
			repeat (4) @(posedge i_ref_clk);
			rd(4'h4);
		end
		chk(d[4], 1);
		chk(8'(rises - r0), 8'd16);
		chk(8'(clears - c0), 8'd16);
		rd(4'h6); chk(d[5:4], 2'h1);
		@(posedge i_ref_clk) cond[0] <= 0;
		wr(4'h0, 8'h02);
		rd(4'h7); chk(d[7:4], 4'h0);
		for (i = 0; i < 60 && on[0] !== 1'b1; i++) @(posedge i_ref_clk);
		chk(on[0], 1);
	endtask
	// unequal select and profile: fault latches, delatch turns on
	task t_disabled;
		int i;
		wr(4'h3, 8'h01);
		@(posedge i_ref_clk) begin cond[1] <= 1; fc[1] <= 1; end
		repeat (8) @(posedge i_ref_clk);
		rd(4'h5); chk(d[4], 1);
		repeat (60) @(posedge i_ref_clk);
		chk(on[1], 0);
		@(posedge i_ref_clk) cond[1] <= 0;
		repeat (6) @(posedge i_ref_clk);
		@(posedge i_ref_clk) dl <= 2'h2;
		@(posedge i_ref_clk) dl <= 2'h0;
		for (i = 0; i < 20 && on[1] !== 1'b1; i++) @(posedge i_ref_clk);
		chk(on[1], 1);
		chk(8'(clears1), 8'd1);
	endtask
	// one short fault gives one restart
	task pulse_fault;
		@(posedge i_ref_clk) cond[0] <= 1;
		repeat (3) @(posedge i_ref_clk);
		cond[0] <= 0;
		repeat (20) @(posedge i_ref_clk);
	endtask
	// fail-safe entry and sleep exit clear the restart counter
	task t_clear_causes;
		wr(4'h0, 8'h00);
		pulse_fault();
		rd(4'h7); chk(d, 8'h10);
		@(posedge i_ref_clk) fs <= 1;
		repeat (3) @(posedge i_ref_clk);
		fs <= 0;
		repeat (4) @(posedge i_ref_clk);
		rd(4'h7); chk(d, 8'h00);
		pulse_fault();
		rd(4'h7); chk(d, 8'h10);
		@(posedge i_ref_clk) se <= 1;
		repeat (3) @(posedge i_ref_clk);
		se <= 0;
		repeat (4) @(posedge i_ref_clk);
		rd(4'h7); chk(d, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_reset_n <= 1;
		t_short();
		t_open_off();
		t_open_on();
		t_retry();
		t_disabled();
		t_clear_causes();
		end_sim();
	end
	initial begin
		#400000;
		failures++;
		end_sim();
	end
endmodule // tb_switch_auto_retry_and_load_diagnostics
